// ### src/tdmfr_pkg.sv
// constants, field layouts and carrier types of the tdm audio framer
// assumes a 32-bit avalon-mm register bus with word addressing
package tdmfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int TDMFR_PINS = 16;
  localparam int TDMFR_ADDR_W = 6;

  // register byte offsets
  localparam logic [7:0] TDMFR_TX_CTRL = 8'h00;
  localparam logic [7:0] TDMFR_RX_CTRL = 8'h04;
  localparam logic [7:0] TDMFR_TX_MASK = 8'h08;
  localparam logic [7:0] TDMFR_RX_MASK = 8'h0C;
  localparam logic [7:0] TDMFR_TX_ROT = 8'h10;
  localparam logic [7:0] TDMFR_RX_ROT = 8'h14;
  localparam logic [7:0] TDMFR_PIN_DIR = 8'h18;
  localparam logic [7:0] TDMFR_STATUS = 8'h1C;
  // per-pin data words: base plus four times the pin number
  localparam logic [1:0] TDMFR_TX_DATA_PAGE = 2'h1;
  localparam logic [1:0] TDMFR_RX_DATA_PAGE = 2'h2;

  // reset values
  localparam logic [31:0] TDMFR_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TDMFR_MASK_RST = 32'hFFFF_FFFF;
  localparam logic [4:0] TDMFR_ROT_RST = 5'h00;

  // slot and word length code: length = base + step * code
  localparam logic [5:0] TDMFR_LEN_BASE = 6'h08;
  localparam logic [5:0] TDMFR_LEN_STEP = 6'h04;

  // link pin order in the synchroniser vector
  localparam int TDMFR_LK_TXC = 0;
  localparam int TDMFR_LK_TXF = 1;
  localparam int TDMFR_LK_RXC = 2;
  localparam int TDMFR_LK_RXF = 3;

  ////////////////////////////////////////////////////////////////////////////
  // pad choice for slot bits outside the word
  typedef enum logic [1:0] {
    TDMFR_PAD_ZERO = 2'h0,
    TDMFR_PAD_ONE = 2'h1,
    TDMFR_PAD_COPY = 2'h2,
    TDMFR_PAD_MSB = 2'h3
  } tdmfr_pad_e;

  // section control word, bit 31 down to bit 0
  typedef struct packed {
    logic spare;
    logic sync_fs;
    logic sync_clk;
    logic fs_master;
    logic fs_width_bit;
    logic fs_pol;
    logic clk_pol;
    logic q31;
    logic [4:0] pad_bit;
    tdmfr_pad_e pad_mode;
    logic lsb_first;
    logic align_right;
    logic [1:0] delay;
    logic [4:0] nslots_m1;
    logic [2:0] word_code;
    logic [2:0] slot_code;
    logic burst;
    logic enable;
  } tdmfr_cfg_s;

  // position of a bit inside a frame
  typedef struct packed {
    logic [4:0] slot;
    logic [4:0] bitp;
  } tdmfr_pos_s;

endpackage

// ### src/tdmfr_top.sv
// tdm audio serial framer: transmit and receive sections on sampled links
// assumes bit clocks well below CLK/4 and a master that holds avalon requests
//
// Contract
// - transmit uses its clock, receive its own
// - receiver may borrow transmit bit clock
// - receiver may borrow transmit frame sync
// - one bit spans one full clock period
// - bit order selectable msb or lsb first
// - short word left or right aligned
// - pad bits zero, one or copied bit
// - slots follow with no idle clocks
// - next frame follows last slot without gap
// - frame sync offset zero, one or two
// - slot boundaries come from bit counting
// - both ends agree on slot length
// - frame sync width slot or one bit
// - frames repeat continuously and periodically
// - stereo format is two-slot tdm
// - stereo word select lasts one slot
// - up to sixteen data pins share timing
// - integer or q31 with rotate and mask
// - continuous tdm or burst per section; as sync master the transmitter keeps running in burst
// - slot and word lengths 8 to 32; length code 7 gives 36 here
// - clock and sync polarity per section
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
module tdmfr_top #(
  parameter int PINS = tdmfr_pkg::TDMFR_PINS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // avalon-mm slave
  input wire logic [tdmfr_pkg::TDMFR_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // transmit link
  input wire logic TRANSMIT_BIT_CLOCK,
  input wire logic TRANSMIT_FRAME_SYNC_IN,
  output logic TRANSMIT_FRAME_SYNC_OUT,
  output logic TRANSMIT_FRAME_SYNC_OE_N,
  // receive link
  input wire logic RECEIVE_BIT_CLOCK,
  input wire logic RECEIVE_FRAME_SYNC,
  // serial data pins
  input wire logic [PINS-1:0] SERIAL_DATA_PIN_IN,
  output logic [PINS-1:0] SERIAL_DATA_PIN_OUT,
  output logic [PINS-1:0] SERIAL_DATA_PIN_OE_N
);
  import tdmfr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // length in bits of a slot or word code
  function automatic logic [5:0] len_of(input logic [2:0] code);
    len_of = TDMFR_LEN_BASE + TDMFR_LEN_STEP * {3'h0, code};
  endfunction

  // next bit position, wrapping slots and frames with no gap
  function automatic tdmfr_pos_s advance(input tdmfr_pos_s p,
      input logic [5:0] sl, input logic [4:0] nm1);
    advance = p;
    if ({1'b0, p.bitp} == sl - 6'h01) begin
      advance.bitp = 5'h00;
      advance.slot = (p.slot == nm1) ? 5'h00 : p.slot + 5'h01;
    end else begin
      advance.bitp = p.bitp + 5'h01;
    end
  endfunction

  // {in word, word bit index} for a slot bit position
  function automatic logic [5:0] map_bit(input logic [4:0] b,
      input logic [5:0] sl, input logic [5:0] wl, input logic right,
      input logic lsb);
    logic [5:0] k;
    logic inw;
    k = right ? {1'b0, b} - (sl - wl) : {1'b0, b};
    inw = right ? ({1'b0, b} >= sl - wl) : ({1'b0, b} < wl);
    map_bit = {inw, lsb ? k[4:0] : 5'(wl - 6'h01 - k)};
  endfunction

  // level of one transmit slot bit, word or pad
  function automatic logic slot_bit(input logic [31:0] fw,
      input logic [4:0] b, input logic [5:0] sl, input logic [5:0] wl,
      input tdmfr_cfg_s c);
    logic [5:0] m;
    m = map_bit(b, sl, wl, c.align_right, c.lsb_first);
    if (m[5]) begin
      slot_bit = fw[m[4:0]];
    end else begin
      case (c.pad_mode)
        TDMFR_PAD_ZERO: slot_bit = 1'b0;
        TDMFR_PAD_ONE: slot_bit = 1'b1;
        TDMFR_PAD_COPY: slot_bit = fw[c.pad_bit];
        default: slot_bit = fw[5'(wl - 6'h01)];
      endcase
    end
  endfunction

  // software word to wire word: mask, rotate right, q31 justify
  function automatic logic [31:0] fmt_tx(input logic [31:0] x,
      input logic [31:0] mask, input logic [4:0] rot, input logic q31,
      input logic [5:0] wl);
    logic [63:0] d;
    d = {x & mask, x & mask} >> rot;
    fmt_tx = q31 ? d[31:0] >> (6'h20 - wl) : d[31:0];
  endfunction

  // wire word to software word: justify, rotate left, mask
  function automatic logic [31:0] fmt_rx(input logic [31:0] a,
      input logic [31:0] mask, input logic [4:0] rot, input logic q31,
      input logic [5:0] wl);
    logic [31:0] w;
    logic [63:0] d;
    w = a & ~(32'hFFFF_FFFF << wl);
    if (q31) begin
      w = w << (6'h20 - wl);
    end
    d = {w, w} << rot;
    fmt_rx = d[63:32] & mask;
  endfunction

  // frame sync active window, leading slot 0 by the bit delay
  function automatic logic fs_window(input tdmfr_pos_s p,
      input logic [5:0] sl, input tdmfr_cfg_s c);
    logic [10:0] f;
    logic [10:0] t;
    logic [10:0] g;
    f = 11'(p.slot) * 11'(sl) + 11'(p.bitp);
    t = (11'(c.nslots_m1) + 11'h001) * 11'(sl);
    g = f + 11'(c.delay);
    if (g >= t) begin
      g = g - t;
    end
    fs_window = g < (c.fs_width_bit ? 11'h001 : 11'(sl));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  tdmfr_cfg_s cfg [0:1];
  logic [31:0] mask [0:1];
  logic [4:0] rot [0:1];
  logic [PINS-1:0] pin_dir;
  logic [31:0] tx_data [0:PINS-1];
  logic [31:0] rx_data [0:PINS-1];
  logic [31:0] acc [0:PINS-1];
  logic [31:0] acc_n [0:PINS-1];
  logic [31:0] tx_fw [0:PINS-1];
  logic [3:0] ls1, ls2, ls3;
  logic [PINS-1:0] d1, d2;
  logic [1:0] clk_rise, clk_fall, samp, drv, fs_act, fs_seen, fs_rise;
  logic [1:0] start, last_bit, next_run, run;
  logic [5:0] slen [0:1];
  logic [5:0] wlen [0:1];
  tdmfr_pos_s cur [0:1];
  tdmfr_pos_s npos [0:1];
  logic [1:0] wait_cnt [0:1];
  logic [7:0] slot_cnt [0:1];
  tdmfr_pos_s dpos;
  logic live, tx_pend, fs_gen, ack, wr, rx_end;
  logic [5:0] rx_m;
  logic [7:0] addr_b;
  logic [3:0] idx;
  logic hit_txd, hit_rxd;
  logic [31:0] rd_mux, status;

  ////////////////////////////////////////////////////////////////////////////
  // link synchronisers: stage one feeds stage two only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ls1 <= 4'h0;
      ls2 <= 4'h0;
      ls3 <= 4'h0;
      d1 <= '0;
      d2 <= '0;
    end else begin
      ls1 <= {RECEIVE_FRAME_SYNC, RECEIVE_BIT_CLOCK,
              TRANSMIT_FRAME_SYNC_IN, TRANSMIT_BIT_CLOCK};
      ls2 <= ls1;
      ls3 <= ls2;
      d1 <= SERIAL_DATA_PIN_IN;
      d2 <= d1;
    end
  end

  // edges of each section's bit clock; receiver may take the transmit one
  assign clk_rise[0] = ls2[TDMFR_LK_TXC] & ~ls3[TDMFR_LK_TXC];
  assign clk_fall[0] = ~ls2[TDMFR_LK_TXC] & ls3[TDMFR_LK_TXC];
  assign clk_rise[1] = cfg[1].sync_clk ? clk_rise[0] :
                       ls2[TDMFR_LK_RXC] & ~ls3[TDMFR_LK_RXC];
  assign clk_fall[1] = cfg[1].sync_clk ? clk_fall[0] :
                       ~ls2[TDMFR_LK_RXC] & ls3[TDMFR_LK_RXC];

  // active frame sync level; a master transmitter loops its own back
  assign fs_act[0] = cfg[0].fs_master ? fs_gen :
                     ls2[TDMFR_LK_TXF] ^ cfg[0].fs_pol;
  assign fs_act[1] = cfg[1].sync_fs ? fs_act[0] :
                     ls2[TDMFR_LK_RXF] ^ cfg[1].fs_pol;

  ////////////////////////////////////////////////////////////////////////////
  // per-section bit and slot counting, identical for both directions but for the transmit master term in next_run
  for (genvar s = 0; s < 2; s++) begin : g_sec
    assign slen[s] = len_of(cfg[s].slot_code);
    assign wlen[s] = len_of(cfg[s].word_code);
    // pol 0 launches on rising and samples on falling
    assign samp[s] = cfg[s].clk_pol ? clk_rise[s] : clk_fall[s];
    assign drv[s] = cfg[s].clk_pol ? clk_fall[s] : clk_rise[s];
    assign fs_rise[s] = samp[s] & fs_act[s] & ~fs_seen[s];
    assign start[s] = cfg[s].enable &
        ((fs_rise[s] & (cfg[s].delay == 2'h0)) |
         (samp[s] & (wait_cnt[s] == 2'h1)));
    assign last_bit[s] = {1'b0, cur[s].bitp} == slen[s] - 6'h01;
    // between syncs only counting finds slot edges
    assign npos[s] = start[s] ? '0 :
        advance(cur[s], slen[s], cfg[s].nslots_m1);
    // burst stops after one slot unless the transmitter is sync master, tdm keeps running
    assign next_run[s] = cfg[s].enable & (start[s] |
        (s == 0 && cfg[s].fs_master) |
        (run[s] & ~(cfg[s].burst & last_bit[s])));
  end

  // counters move on sample edges; disabling parks them
  always_ff @(posedge CLK) begin
    for (int s = 0; s < 2; s++) begin
      if (RESET) begin
        cur[s] <= '0;
        run[s] <= 1'b0;
        wait_cnt[s] <= 2'h0;
        fs_seen[s] <= 1'b0;
        slot_cnt[s] <= 8'h00;
      end else if (!cfg[s].enable) begin
        run[s] <= 1'b0;
        wait_cnt[s] <= 2'h0;
      end else if (samp[s]) begin
        cur[s] <= npos[s];
        run[s] <= next_run[s];
        fs_seen[s] <= fs_act[s];
        if (fs_rise[s] && cfg[s].delay != 2'h0) begin
          wait_cnt[s] <= cfg[s].delay;
        end else if (wait_cnt[s] != 2'h0) begin
          wait_cnt[s] <= wait_cnt[s] - 2'h1;
        end
        if (run[s] && last_bit[s]) begin
          slot_cnt[s] <= slot_cnt[s] + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: launch the next bit of every output pin on the drive edge
  // a start due at the next sample means slot 0 bit 0 leaves now; an idle
  // burst section would otherwise lose that bit while run is still low
  assign tx_pend = cfg[0].enable & (wait_cnt[0] == 2'h1);
  assign dpos = tx_pend ? '0 : advance(cur[0], slen[0], cfg[0].nslots_m1);
  assign live = tx_pend | (run[0] & ~(cfg[0].burst & last_bit[0]));

  for (genvar n = 0; n < PINS; n++) begin : g_txf
    assign tx_fw[n] = fmt_tx(tx_data[n], mask[0], rot[0],
                             cfg[0].q31, wlen[0]);
  end

  // all pins share one position, so they stay in lockstep
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SERIAL_DATA_PIN_OUT <= '0;
      fs_gen <= 1'b0;
      TRANSMIT_FRAME_SYNC_OUT <= 1'b0;
    end else if (drv[0]) begin
      for (int n = 0; n < PINS; n++) begin
        SERIAL_DATA_PIN_OUT[n] <= live & pin_dir[n] &
            slot_bit(tx_fw[n], dpos.bitp, slen[0], wlen[0],
                     cfg[0]);
      end
      // width one slot gives stereo word select with two slots
      fs_gen <= cfg[0].enable & cfg[0].fs_master &
                fs_window(dpos, slen[0], cfg[0]);
      TRANSMIT_FRAME_SYNC_OUT <= cfg[0].fs_pol ^ (cfg[0].enable &
          cfg[0].fs_master & fs_window(dpos, slen[0], cfg[0]));
    end
  end

  assign TRANSMIT_FRAME_SYNC_OE_N = ~cfg[0].fs_master;
  assign SERIAL_DATA_PIN_OE_N = ~pin_dir;

  ////////////////////////////////////////////////////////////////////////////
  // receive: place each sampled bit at its word position
  assign rx_m = map_bit(npos[1].bitp, slen[1], wlen[1],
                        cfg[1].align_right, cfg[1].lsb_first);
  assign rx_end = {1'b0, npos[1].bitp} == slen[1] - 6'h01;

  for (genvar n = 0; n < PINS; n++) begin : g_rxa
    // pad bits are not stored, only word bits
    assign acc_n[n] = rx_m[5] ?
        ((acc[n] & ~(32'h0000_0001 << rx_m[4:0])) |
         ({31'h0, d2[n]} << rx_m[4:0])) : acc[n];
  end

  // the word is handed over at the last slot bit, no deeper buffer
  always_ff @(posedge CLK) begin
    for (int n = 0; n < PINS; n++) begin
      if (RESET) begin
        acc[n] <= 32'h0000_0000;
        rx_data[n] <= 32'h0000_0000;
      end else if (samp[1] && next_run[1] && !pin_dir[n]) begin
        acc[n] <= rx_end ? 32'h0000_0000 : acc_n[n];
        if (rx_end) begin
          rx_data[n] <= fmt_rx(acc_n[n], mask[1], rot[1],
                               cfg[1].q31, wlen[1]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, then answer
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr = AVS_WRITE & ack;
  assign addr_b = {AVS_ADDRESS, 2'b00};
  assign idx = addr_b[5:2];
  assign hit_txd = (addr_b[7:6] == TDMFR_TX_DATA_PAGE) && (int'(idx) < PINS);
  assign hit_rxd = (addr_b[7:6] == TDMFR_RX_DATA_PAGE) && (int'(idx) < PINS);
  assign status = {slot_cnt[1], slot_cnt[0], 1'b0, cur[1].slot,
                   cur[0].slot, 3'h0, run[1], run[0]};
  // unmapped addresses read as zero and ignore writes
  assign rd_mux = hit_txd ? tx_data[idx] :
                  hit_rxd ? rx_data[idx] :
                  (addr_b == TDMFR_TX_CTRL) ? cfg[0] :
                  (addr_b == TDMFR_RX_CTRL) ? cfg[1] :
                  (addr_b == TDMFR_TX_MASK) ? mask[0] :
                  (addr_b == TDMFR_RX_MASK) ? mask[1] :
                  (addr_b == TDMFR_TX_ROT) ? {27'h0, rot[0]} :
                  (addr_b == TDMFR_RX_ROT) ? {27'h0, rot[1]} :
                  (addr_b == TDMFR_PIN_DIR) ? 32'(pin_dir) :
                  (addr_b == TDMFR_STATUS) ? status : 32'h0000_0000;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // handshake and read data
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
      if (AVS_READ && !ack) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // register writes take effect at the edge that ends the wait
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg[0] <= TDMFR_CTRL_RST;
      cfg[1] <= TDMFR_CTRL_RST;
      mask[0] <= TDMFR_MASK_RST;
      mask[1] <= TDMFR_MASK_RST;
      rot[0] <= TDMFR_ROT_RST;
      rot[1] <= TDMFR_ROT_RST;
      pin_dir <= '0;
      for (int n = 0; n < PINS; n++) begin
        tx_data[n] <= 32'h0000_0000;
      end
    end else if (wr) begin
      if (addr_b == TDMFR_TX_CTRL)
        cfg[0] <= be_merge(cfg[0], AVS_WRITEDATA, AVS_BYTEENABLE);
      if (addr_b == TDMFR_RX_CTRL)
        cfg[1] <= be_merge(cfg[1], AVS_WRITEDATA, AVS_BYTEENABLE);
      if (addr_b == TDMFR_TX_MASK)
        mask[0] <= be_merge(mask[0], AVS_WRITEDATA, AVS_BYTEENABLE);
      if (addr_b == TDMFR_RX_MASK)
        mask[1] <= be_merge(mask[1], AVS_WRITEDATA, AVS_BYTEENABLE);
      if (addr_b == TDMFR_TX_ROT && AVS_BYTEENABLE[0])
        rot[0] <= AVS_WRITEDATA[4:0];
      if (addr_b == TDMFR_RX_ROT && AVS_BYTEENABLE[0])
        rot[1] <= AVS_WRITEDATA[4:0];
      if (addr_b == TDMFR_PIN_DIR)
        pin_dir <= PINS'(be_merge(32'(pin_dir), AVS_WRITEDATA,
                                  AVS_BYTEENABLE));
      for (int n = 0; n < PINS; n++) begin
        if (hit_txd && int'(idx) == n)
          tx_data[n] <= be_merge(tx_data[n], AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_last_of_frame;
    cfg[0].enable && samp[0] && last_bit[0] && !start[0] &&
    cur[0].slot == cfg[0].nslots_m1;
  endsequence

  sequence s_mid_slot_rx;
    cfg[1].enable && samp[1] && !start[1] && !last_bit[1];
  endsequence

  a_frame_wrap: assert property (s_last_of_frame |=> cur[0] == '0)
    else $error("frame did not wrap to slot 0 bit 0");
  a_bit_step: assert property (s_mid_slot_rx |=>
      cur[1].bitp == $past(cur[1].bitp) + 5'h01 &&
      cur[1].slot == $past(cur[1].slot))
    else $error("receive bit counter skipped");
  a_sync_zero: assert property (cfg[0].enable && fs_rise[0] &&
      cfg[0].delay == 2'h0 |=> cur[0] == '0 && run[0])
    else $error("zero delay sync did not restart frame");
  a_delay_load: assert property (cfg[1].enable && fs_rise[1] &&
      cfg[1].delay != 2'h0 |=> wait_cnt[1] == $past(cfg[1].delay))
    else $error("bit delay not loaded");
  a_burst_stop: assert property (cfg[0].enable && cfg[0].burst &&
      !cfg[0].fs_master && samp[0] && last_bit[0] && !start[0]
      |=> !run[0])
    else $error("burst kept running past its slot");
  a_tx_stable: assert property (!drv[0] |=>
      $stable(SERIAL_DATA_PIN_OUT))
    else $error("data changed away from drive edge");
  a_rx_clk_pick: assert property (cfg[1].sync_clk |->
      clk_rise[1] == clk_rise[0] && clk_fall[1] == clk_fall[0])
    else $error("receiver not on transmit clock");
  a_rx_fs_pick: assert property (cfg[1].sync_fs |->
      fs_act[1] == fs_act[0])
    else $error("receiver not on transmit frame sync");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) &&
      AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer later than one wait state");

endmodule

// ### tb/tdmfr_codec.sv
// behavioural codec at the far end of one tdm link
// assumes the framer launches on rising and samples on falling bit clock
module tdmfr_codec (
  // link
  output logic bit_clk,
  output logic sync,
  output logic sdo,
  input wire logic sdi,
  // framing chosen by the bench
  input wire logic [5:0] slot_bits,
  input wire logic [1:0] delay,
  input wire logic [31:0] word,
  // slot words captured from the framer
  output logic [31:0] got0,
  output logic [31:0] got1
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos;
  int frame;
  int half;
  logic [31:0] sh;
  //////////////////////////////////////////////////////////////////////////
  // bit clock runs free, since tdm frames follow one another with no gap
  initial begin
    bit_clk = 1'b0;
    pos = 0;
    #37;
    forever #200 bit_clk = ~bit_clk;
  end
  assign half = int'(slot_bits); // same slot length as the framer
  assign frame = 2 * half;
  // at a rising edge the framer's previous bit has long settled
  always @(posedge bit_clk) begin
    sh = {sh[30:0], sdi};
    if (pos == half - 1) got0 <= sh & (32'hFFFFFFFF >> (32 - half));
    if (pos == frame - 1) got1 <= sh & (32'hFFFFFFFF >> (32 - half));
    pos = (pos >= frame - 1) ? 0 : pos + 1;
    sync <= (pos == (frame - int'(delay)) % frame); // one bit wide
    sdo <= word[half - 1 - pos % half]; // msb first, gapless
  end
endmodule

// ### tb/tdmfr_top_tb.sv
// self-checking bench: avalon register access plus one codec link
// assumes the codec is told the same framing as the framer
module tdmfr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tdmfr_pkg::*;
  localparam int CLK_PER_BIT = 8; // 400 ns link clock on 50 ns CLK
  logic clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, word, got0, got1, rd;
  logic sync_out, sync_oe_n, rx_own, link_clk, link_sync, link_sdo;
  logic [15:0] pin_out, pin_oe_n;
  logic [5:0] slot_bits;
  logic [1:0] delay;
  tdmfr_cfg_s c;
  int num_errors;
  int samples_checked;
  //////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  // sync pin is shared: the framer drives it only as master
  tdmfr_top i_dut (
    .CLK(clk), .RESET(reset),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .TRANSMIT_BIT_CLOCK(link_clk),
    .TRANSMIT_FRAME_SYNC_IN(sync_oe_n ? link_sync : sync_out),
    .TRANSMIT_FRAME_SYNC_OUT(sync_out), .TRANSMIT_FRAME_SYNC_OE_N(sync_oe_n),
    .RECEIVE_BIT_CLOCK(rx_own ? link_clk : 1'b0),
    .RECEIVE_FRAME_SYNC(rx_own ? link_sync : 1'b0),
    .SERIAL_DATA_PIN_IN({16{link_sdo}}), .SERIAL_DATA_PIN_OUT(pin_out),
    .SERIAL_DATA_PIN_OE_N(pin_oe_n));
  tdmfr_codec i_codec (.bit_clk(link_clk), .sync(link_sync), .sdo(link_sdo),
    .sdi(pin_out[0]), .slot_bits(slot_bits), .delay(delay), .word(word),
    .got0(got0), .got1(got1));
  //////////////////////////////////////////////////////////////////////////
  // one avalon transfer: held until waitrequest is seen low at an edge
  task bus(input logic we, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= !we;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // flags: right align, lsb first, q31, burst, receiver borrows tx timing
  task run_case(input logic [2:0] sc, input logic [1:0] d,
      input logic [1:0] pad, input logic [4:0] f, input logic [31:0] txd,
      input logic [31:0] txe, input logic [31:0] cw, input logic [31:0] rxe);
    c = tdmfr_cfg_s'(TDMFR_CTRL_RST);
    c.enable = 1'b1;
    c.slot_code = sc;
    c.nslots_m1 = 5'h01; // two slots: stereo layout with a one-bit frame sync
    c.delay = d;
    c.pad_mode = tdmfr_pad_e'(pad);
    {c.align_right, c.lsb_first, c.q31, c.burst} = f[4:1];
    c.fs_width_bit = 1'b1;
    rx_own <= !f[0];
    slot_bits <= 6'(TDMFR_LEN_BASE + TDMFR_LEN_STEP * sc);
    delay <= d;
    word <= cw;
    bus(1'b1, {TDMFR_TX_DATA_PAGE, 4'h0}, txd);
    bus(1'b1, TDMFR_TX_CTRL[7:2], c);
    {c.sync_clk, c.sync_fs} = {2{f[0]}};
    bus(1'b1, TDMFR_RX_CTRL[7:2], c);
    repeat (CLK_PER_BIT * 6 * int'(slot_bits) + 300) @(posedge clk);
    @(negedge clk);
    chk("tx slot 0", got0, txe);
    chk("tx slot 1", got1, f[1] ? 32'h0 : txe);
    bus(1'b0, {TDMFR_RX_DATA_PAGE, 4'h1}, 32'h0);
    chk("rx word", rd, rxe);
    $display("test done: slot code %0d flags %b", sc, f);
  endtask
  // master sync width in system clocks, one edge of slack per end
  task sync_width(input logic bitw, input int exp);
    int n;
    c = tdmfr_cfg_s'(TDMFR_CTRL_RST);
    {c.enable, c.nslots_m1, c.delay} = {1'b1, 5'h01, 2'h1};
    {c.fs_master, c.fs_width_bit} = {1'b1, bitw};
    bus(1'b1, TDMFR_TX_CTRL[7:2], c);
    repeat (300) @(posedge clk);
    for (n = 0; n < 400 && sync_out !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 400 && sync_out !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 400 && sync_out === 1'b1; n++) @(negedge clk);
    chk("sync driven", 32'(sync_oe_n), 32'h0);
    chk("sync width", 32'(n >= exp - 1 && n <= exp + 1), 32'h1);
    $display("test done: master sync width %0d", exp);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, reset, avs_read, avs_write, rx_own} = 5'b01001;
    {avs_address, avs_byteenable, avs_writedata} = {6'h00, 4'hF, 32'h0};
    {slot_bits, delay, word} = {6'h08, 2'h1, 32'h0};
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    chk("pin oe_n reset", 32'(pin_oe_n), 32'hFFFF);
    bus(1'b0, TDMFR_TX_CTRL[7:2], 32'h0);
    chk("tx ctrl reset", rd, TDMFR_CTRL_RST);
    bus(1'b0, TDMFR_TX_MASK[7:2], 32'h0);
    chk("tx mask reset", rd, TDMFR_MASK_RST);
    bus(1'b1, 6'h3F, 32'hFFFFFFFF);
    bus(1'b0, 6'h3F, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, TDMFR_PIN_DIR[7:2], 32'h1);
    @(negedge clk);
    chk("pin oe_n", 32'(pin_oe_n), 32'hFFFE);
    $display("test done: reset and map");
    run_case(3'h0, 2'h1, 2'h0, 5'h00, 32'hC1, 32'hC1, 32'h36, 32'h36);
    run_case(3'h0, 2'h1, 2'h0, 5'h08, 32'hC1, 32'h83, 32'h36, 32'h6C);
    run_case(3'h0, 2'h0, 2'h0, 5'h00, 32'hC1, 32'hC1, 32'h36, 32'h36);
    run_case(3'h0, 2'h2, 2'h0, 5'h00, 32'hC1, 32'hC1, 32'h36, 32'h36);
    run_case(3'h1, 2'h1, 2'h1, 5'h00, 32'hC1, 32'hC1F, 32'h36A, 32'h36);
    run_case(3'h1, 2'h1, 2'h0, 5'h10, 32'hC1, 32'h0C1, 32'h36A, 32'h6A);
    run_case(3'h1, 2'h1, 2'h2, 5'h10, 32'hC1, 32'hFC1, 32'h36A, 32'h6A);
    run_case(3'h1, 2'h1, 2'h3, 5'h00, 32'h41, 32'h410, 32'h36A, 32'h36);
    run_case(3'h6, 2'h1, 2'h0, 5'h00, 32'hC1, 32'hC1000000, 32'h36000000,
      32'h36);
    run_case(3'h0, 2'h1, 2'h0, 5'h04, 32'hC1000000, 32'hC1, 32'h36,
      32'h36000000);
    run_case(3'h0, 2'h1, 2'h0, 5'h02, 32'hC1, 32'hC1, 32'h36, 32'h36);
    run_case(3'h0, 2'h1, 2'h0, 5'h01, 32'hC1, 32'hC1, 32'h36, 32'h36);
    bus(1'b1, TDMFR_TX_MASK[7:2], 32'h0000000F);
    bus(1'b1, TDMFR_TX_ROT[7:2], 32'h0000001C);
    bus(1'b1, TDMFR_RX_MASK[7:2], 32'h00000FF0);
    bus(1'b1, TDMFR_RX_ROT[7:2], 32'h00000004);
    run_case(3'h0, 2'h1, 2'h0, 5'h00, 32'hC1, 32'h10, 32'h36, 32'h360);
    sync_width(1'b0, 8 * CLK_PER_BIT);
    sync_width(1'b1, CLK_PER_BIT);
    end_sim();
  end
  // watchdog sized well past the longest expected run
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
